// file: src/wiper_pkg.sv
package wiper_pkg;

	// ----------------------------------------------------------------
	// bus address
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_FIXED_HI = 4'h5;
	localparam logic [1:0] ADDR_FACTORY_DEF = 2'h0;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_VOLATILE_WIPER_WRITE    = 8'h11;
	localparam logic [7:0] CMD_PERSISTENT_STORE_WRITE  = 8'h21;
	localparam logic [7:0] CMD_RESTORE_FROM_PERSISTENT = 8'h61;
	localparam logic [7:0] CMD_SAVE_TO_PERSISTENT      = 8'h51;

	// ----------------------------------------------------------------
	// values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] MIDSCALE       = 8'h80;
	localparam logic [3:0] BIT_LAST       = 4'h7;
	localparam logic [3:0] BIT_ACK        = 4'h8;
	localparam int         CLK_HZ         = 20_000_000;
	localparam int         INIT_TIME_NS   = 10_000;
	localparam int         INIT_CYCLES    = (INIT_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int         INIT_W         = 9;
	localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);

	// ----------------------------------------------------------------
	// frame phase and pin bundle
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_ADDR = 3'b001,
		PH_CMD  = 3'b011,
		PH_DATA = 3'b010,
		PH_SKIP = 3'b110
	} phase_e;

	typedef struct packed {
		logic scl;
		logic sda;
	} bus_pins_s;

endpackage

// file: src/wiper_command_decoder.sv
// Behaviour
// - the first byte after the address is the command, all later bytes are data.
// - the first data byte goes to the register the command selects.
// - volatile write stores the data in the wiper register, which drives the wiper.
// - persistent write stores the data only in the persistent register.
// - restore copies the persistent value into the wiper register.
// - save copies the wiper register into the persistent register.
// - command codes are 11h, 21h, 61h, 51h, sent MSB first; data is ignored for copies.
// - the persistent register is 8 bits and starts at midscale.
// - after reset the persistent value is loaded into the wiper within 10 us.
// - once the power-up load is done, the block idles in standby whenever no frame is in progress.
// - only address 0101, two factory bits, and the select pin is answered.
// - an address with the eighth bit high is a no-operation.
// - each byte of a matching write frame is acknowledged by holding SDA low over the ninth clock.
`timescale 1ns/1ps
module wiper_command_decoder
	import wiper_pkg::*;
#(
	parameter logic [1:0] FACTORY_BITS = ADDR_FACTORY_DEF
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// two-wire bus pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// strap
	input  wire logic       address_select_pin_i,
	// wiper and status
	output logic [7:0]      wiper_o,
	output logic [7:0]      persistent_o,
	output logic            init_done_o,
	output logic            standby_o
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// the strap is synchronised too, since a board may move it live; the
	// two stages cost a few clocks of latency, small against a bus bit
	localparam int PIN_COUNT = 3;
	localparam int PIN_SCL   = 0;
	localparam int PIN_SDA   = 1;
	localparam int PIN_SEL   = 2;

	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_meta_r;
	logic [PIN_COUNT-1:0] pin_sync_r;
	bus_pins_s            pins_r;
	bus_pins_s            pins_d_r;
	logic                 sel_sync;

	assign pin_raw = {address_select_pin_i, sda_i, scl_i};

	always_ff @(posedge clk_i) begin
		pin_meta_r <= pin_raw;
		pin_sync_r <= pin_meta_r;
	end

	assign pins_r   = '{scl: pin_sync_r[PIN_SCL], sda: pin_sync_r[PIN_SDA]};
	assign sel_sync = pin_sync_r[PIN_SEL];

	// a third stage on the bus pins only, for edge and start/stop detection
	always_ff @(posedge clk_i) begin
		pins_d_r <= pins_r;
	end

	// ----------------------------------------------------------------
	// bus events
	// ----------------------------------------------------------------
	wire scl_rise  = pins_r.scl & ~pins_d_r.scl;
	wire scl_fall  = ~pins_r.scl & pins_d_r.scl;
	wire start_det = pins_r.scl & pins_d_r.scl & pins_d_r.sda & ~pins_r.sda;
	wire stop_det  = pins_r.scl & pins_d_r.scl & ~pins_d_r.sda & pins_r.sda;

	// ----------------------------------------------------------------
	// byte shifter
	// ----------------------------------------------------------------
	logic [3:0] bit_r;
	logic [3:0] bit_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic       ack_r;
	logic       ack_nxt;

	// the ninth pulse is the acknowledge slot; nothing is shifted there
	wire       shift_take = scl_rise & ~ack_r;
	wire       ack_enter  = scl_fall & (bit_r == BIT_ACK) & ~ack_r;
	wire       ack_leave  = scl_fall & ack_r;
	wire       byte_done  = shift_take & (bit_r == BIT_LAST);
	wire [7:0] shift_in   = {shift_r[6:0], pins_r.sda};
	wire [6:0] my_addr    = {ADDR_FIXED_HI, FACTORY_BITS, sel_sync};
	wire       addr_match = (shift_in[7:1] == my_addr);
	wire       write_bit  = ~shift_in[0];

	assign shift_nxt = shift_take ? shift_in : shift_r;
	assign bit_nxt   = (start_det | ack_leave) ? 4'h0
	                 : (shift_take ? bit_r + 4'h1 : bit_r);
	assign ack_nxt   = ~(start_det | ack_leave) & (ack_enter | ack_r);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bit_r <= 4'h0;
		end else begin
			bit_r <= bit_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shift_r <= 8'h00;
		end else begin
			shift_r <= shift_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= ack_nxt;
		end
	end

	// ----------------------------------------------------------------
	// frame phase
	// ----------------------------------------------------------------
	phase_e phase_r;
	phase_e phase_nxt;

	// a start anywhere restarts the frame, so a repeated start is honoured
	always_comb begin
		phase_nxt = phase_r;
		if (start_det) begin
			phase_nxt = PH_ADDR;
		end else if (stop_det) begin
			phase_nxt = PH_IDLE;
		end else if (byte_done) begin
			unique case (phase_r)
				PH_ADDR: phase_nxt = (addr_match & write_bit) ? PH_CMD : PH_SKIP;
				PH_CMD:  phase_nxt = PH_DATA;
				PH_DATA: phase_nxt = PH_DATA;
				PH_SKIP: phase_nxt = PH_SKIP;
				PH_IDLE: phase_nxt = PH_IDLE;
				default: phase_nxt = PH_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_r <= PH_IDLE;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic [7:0] cmd_r;
	logic [7:0] cmd_nxt;
	logic       data_seen_r;
	logic       data_seen_nxt;

	wire is_vol   = (cmd_r == CMD_VOLATILE_WIPER_WRITE);
	wire is_pers  = (cmd_r == CMD_PERSISTENT_STORE_WRITE);
	wire is_rest  = (cmd_r == CMD_RESTORE_FROM_PERSISTENT);
	wire is_save  = (cmd_r == CMD_SAVE_TO_PERSISTENT);
	// only the first data byte acts; later ones are acked and dropped
	wire data_now = byte_done & (phase_r == PH_DATA) & ~data_seen_r;
	wire cmd_now  = byte_done & (phase_r == PH_CMD);

	assign cmd_nxt       = cmd_now ? shift_in : cmd_r;
	assign data_seen_nxt = ~start_det & (data_now | data_seen_r);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_r <= 8'h00;
		end else begin
			cmd_r <= cmd_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_seen_r <= 1'b0;
		end else begin
			data_seen_r <= data_seen_nxt;
		end
	end

	// ----------------------------------------------------------------
	// acknowledge drive
	// ----------------------------------------------------------------
	// pull low from the fall after bit 8 until the fall that ends the
	// ninth clock, so SDA is steady over its high; the phase has moved on
	// by then, so a matching write address is acked as well as the bytes
	// after it, and a skipped frame is never acked
	logic sda_oe_nxt;

	wire ack_want = (phase_r == PH_CMD) | (phase_r == PH_DATA);

	assign sda_oe_nxt = (start_det | stop_det) ? 1'b0
	                  : ack_enter ? ack_want
	                  : (ack_leave ? 1'b0 : sda_oe_o);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sda_oe_o <= 1'b0;
			sda_o    <= 1'b0;
		end else begin
			sda_oe_o <= sda_oe_nxt;
			sda_o    <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// power-up load
	// ----------------------------------------------------------------
	// reset stands in for power-up; the wiper follows the persistent
	// value for the whole load time, and frames arriving meanwhile are
	// acked but not applied
	logic [INIT_W-1:0] init_cnt_r;
	logic [INIT_W-1:0] init_cnt_nxt;
	logic              init_done_r;
	logic              init_done_nxt;

	wire init_end = ~init_done_r & (init_cnt_r == INIT_LAST);

	assign init_cnt_nxt  = init_done_r ? init_cnt_r : init_cnt_r + INIT_W'(1);
	assign init_done_nxt = init_done_r | init_end;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			init_cnt_r <= '0;
		end else begin
			init_cnt_r <= init_cnt_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			init_done_r <= 1'b0;
			init_done_o <= 1'b0;
		end else begin
			init_done_r <= init_done_nxt;
			init_done_o <= init_done_nxt;
		end
	end

	// ----------------------------------------------------------------
	// wiper and persistent registers
	// ----------------------------------------------------------------
	// the persistent store is a plain register here, so it comes back at
	// the factory value on every reset
	logic [7:0] wiper_nxt;
	logic [7:0] persistent_nxt;

	wire apply   = init_done_r & data_now;
	wire do_vol  = apply & is_vol;
	wire do_pers = apply & is_pers;
	wire do_rest = apply & is_rest;
	wire do_save = apply & is_save;

	assign wiper_nxt = ~init_done_r ? persistent_o
	                 : do_vol ? shift_in
	                 : do_rest ? persistent_o
	                 : wiper_o;
	assign persistent_nxt = do_pers ? shift_in
	                      : do_save ? wiper_o
	                      : persistent_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wiper_o <= 8'h00;
		end else begin
			wiper_o <= wiper_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			persistent_o <= MIDSCALE;
		end else begin
			persistent_o <= persistent_nxt;
		end
	end

	// ----------------------------------------------------------------
	// standby
	// ----------------------------------------------------------------
	// a status flag only: no clock is gated here, so the power saving is
	// left to whatever sits around this block
	logic standby_nxt;

	assign standby_nxt = (phase_nxt == PH_IDLE) & init_done_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			standby_o <= 1'b0;
		end else begin
			standby_o <= standby_nxt;
		end
	end

endmodule

// file: bench/wiper_command_decoder_asserts.sv
`timescale 1ns/1ps
module wiper_checker
	import wiper_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       scl_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	input wire logic [7:0] wiper_o,
	input wire logic [7:0] persistent_o,
	input wire logic       init_done_o,
	input wire logic       standby_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_RST: assert property (disable iff (1'b0) rst_i |=> persistent_o == MIDSCALE)
		else $error("persistent not midscale after reset");
	AST_INIT_LOAD: assert property (!init_done_o |=> wiper_o == $past(persistent_o))
		else $error("wiper not loaded from persistent");
	AST_INIT_TIME: assert property ($fell(rst_i) |-> ##[1:201] init_done_o)
		else $error("init too slow");
	AST_ACK_LOW: assert property (sda_oe_o |-> !sda_o)
		else $error("ack drives high");
	AST_ACK_START: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("ack starts with scl high");
	AST_ACK_HOLD: assert property (sda_oe_o && scl_i |=> sda_oe_o)
		else $error("ack dropped in high phase");
	AST_STBY_INIT: assert property (standby_o |-> init_done_o)
		else $error("standby before init");
	AST_STBY_QUIET: assert property (standby_o && $past(standby_o)
		|-> $stable(wiper_o) && $stable(persistent_o))
		else $error("register moved in standby");
endmodule

// file: bench/bus_master.sv
`timescale 1ns/1ps
module bus_master (
	input  wire logic clk_i,
	input  wire logic sda_oe_i,
	output logic      scl_o,
	output logic      sda_o
);
	int   acks = 0;
	logic seen;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// data moves two cycles clear of the scl fall so it never looks like start or stop
	task automatic clk_bit(input logic b);
		repeat (2) @(negedge clk_i);
		sda_o = b;
		repeat (4) @(negedge clk_i);
		scl_o = 1'b1;
		repeat (5) @(negedge clk_i);
		seen = sda_oe_i;
		scl_o = 1'b0;
	endtask
	task automatic send(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) clk_bit(v[i]);
		clk_bit(1'b1);
		if (seen === 1'b1) acks++;
	endtask
	task automatic frame(input logic [7:0] a, c, d, input int n);
		acks = 0;
		sda_o = 1'b0;
		repeat (5) @(negedge clk_i);
		scl_o = 1'b0;
		send(a);
		if (n > 1) send(c);
		if (n > 2) send(d);
		if (n > 3) send(~d);
		repeat (2) @(negedge clk_i);
		sda_o = 1'b0;
		repeat (4) @(negedge clk_i);
		scl_o = 1'b1;
		repeat (4) @(negedge clk_i);
		sda_o = 1'b1;
		repeat (10) @(negedge clk_i);
	endtask
endmodule

// file: bench/wiper_command_decoder_tb.sv
`timescale 1ns/1ps
module wiper_command_decoder_tb;
	import wiper_pkg::*;
	localparam logic [7:0] ADR = {ADDR_FIXED_HI, ADDR_FACTORY_DEF, 2'b10};
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       scl, msda, oe, sdo, std, idn;
	logic [7:0] wip, per;
	int         fails = 0;
	int         samples_checked = 0;
	// open drain with pull-up
	wire logic  sda = msda & ~(oe & ~sdo);
	always #25 clk = ~clk;
	bus_master i_bus_master (.clk_i(clk), .sda_oe_i(oe), .scl_o(scl), .sda_o(msda));
	wiper_command_decoder i_wiper_command_decoder (.clk_i(clk), .rst_i(rst), .scl_i(scl),
		.sda_i(sda), .sda_o(sdo), .sda_oe_o(oe), .address_select_pin_i(1'b1),
		.wiper_o(wip), .persistent_o(per), .init_done_o(idn), .standby_o(std));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic judge(input logic [7:0] w, input logic [7:0] p, input int a);
		check(wip, w);
		check(per, p);
		check({7'h0, std}, 8'h01);
		check(8'(i_bus_master.acks), 8'(a));
	endtask
	task automatic t_reset;
		for (int i = 0; i < 300 && idn !== 1'b1; i++) @(negedge clk);
		check({7'h0, idn}, 8'h01);
		repeat (2) @(negedge clk);
		judge(MIDSCALE, MIDSCALE, 0);
	endtask
	task automatic t_vol;
		i_bus_master.frame(ADR, CMD_VOLATILE_WIPER_WRITE, 8'h3C, 4);
		judge(8'h3C, MIDSCALE, 4);
	endtask
	task automatic t_nv;
		i_bus_master.frame(ADR, CMD_PERSISTENT_STORE_WRITE, 8'hA5, 3);
		judge(8'h3C, 8'hA5, 3);
	endtask
	task automatic t_restore;
		i_bus_master.frame(ADR, CMD_RESTORE_FROM_PERSISTENT, 8'h00, 3);
		judge(8'hA5, 8'hA5, 3);
	endtask
	task automatic t_save;
		i_bus_master.frame(ADR, CMD_VOLATILE_WIPER_WRITE, 8'h5A, 3);
		i_bus_master.frame(ADR, CMD_SAVE_TO_PERSISTENT, 8'hFF, 3);
		judge(8'h5A, 8'h5A, 3);
	endtask
	task automatic t_refuse;
		i_bus_master.frame(ADR, 8'h31, 8'h11, 3);
		judge(8'h5A, 8'h5A, 3);
		i_bus_master.frame(ADR | 8'h01, CMD_VOLATILE_WIPER_WRITE, 8'h22, 3);
		judge(8'h5A, 8'h5A, 0);
		i_bus_master.frame(ADR ^ 8'h02, CMD_VOLATILE_WIPER_WRITE, 8'h22, 3);
		judge(8'h5A, 8'h5A, 0);
		i_bus_master.frame(ADR, CMD_VOLATILE_WIPER_WRITE, 8'h22, 2);
		judge(8'h5A, 8'h5A, 2);
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_vol();
		t_nv();
		t_restore();
		t_save();
		t_refuse();
		summarize();
	end
endmodule
bind wiper_command_decoder wiper_checker i_wiper_checker (.clk_i(clk_i), .rst_i(rst_i),
	.scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wiper_o(wiper_o),
	.persistent_o(persistent_o), .init_done_o(init_done_o), .standby_o(standby_o));
